//--- rtl/tecrc_timer.sv
`timescale 1ns/1ps
module tecrc_timer #(
    parameter bit DIVIDER_OPTION = 1'b1
) (
    input wire logic sys_clk_i,
    input wire logic reset_n_i,
    input wire tecrc_pkg::tecrc_bus_req_t bus_i,
    output logic [7:0] rdata_o,
    input wire tecrc_pkg::tecrc_src_t src_i,
    input wire logic count_input_pin_i,
    input wire logic timer_int_enable_i,
    input wire logic flag_wr_i,
    input wire logic flag_wdata_i,
    input wire logic divider_port_bit_i,
    output logic overflow_flag_o,
    output logic int_req_o,
    output logic wakeup_o,
    output logic freq_divider_output_o
);

    ////////////////////////////////////////////////////////////////
    // Registers and decode

    localparam int INSTR_DIV_W_L = tecrc_pkg::INSTR_DIV_W;

    logic [7:0] ctl_q;
    logic [7:0] conv_q;
    logic [7:0] wr_buf_a_q;
    logic [7:0] wr_buf_b_q;
    logic [15:0] preload_q;
    logic [INSTR_DIV_W_L-1:0] div_q;
    logic pin_q;
    logic pw_active_q;
    logic flag_q;
    logic pfd_q;
    logic rd_stall_q;

    logic count_on;
    logic conv_mode;
    tecrc_pkg::tecrc_mode_t mode;
    logic [3:0] osc_sel;
    logic locked;
    logic wr_ah, wr_al, wr_bh, wr_bl, wr_ctl, wr_conv, rd_ah, rd_bh;
    logic instr_tick;
    logic a_src, b_src;
    logic a_tick, b_tick;
    logic ld_a, ld_b;
    logic [15:0] cnt_a, cnt_b;
    logic [7:0] lbuf_a, lbuf_b;
    logic ovf_a, ovf_b;
    logic ovf_evt;
    logic pw_start, pw_end;
    logic pin_edge_rise, pin_edge_fall;

    assign count_on = ctl_q[tecrc_pkg::CTL_ON_BIT];
    assign conv_mode = conv_q[tecrc_pkg::CONV_MODE_BIT];
    assign mode = tecrc_pkg::tecrc_mode_t'(ctl_q[7:tecrc_pkg::CTL_MODE_LSB]);
    assign osc_sel = conv_q[7:tecrc_pkg::CONV_OSC_LSB];

    assign locked = count_on;
    assign wr_ah = bus_i.wr && !locked
        && bus_i.addr == tecrc_pkg::ADDR_COUNT_HIGH;
    assign wr_al = bus_i.wr && !locked
        && bus_i.addr == tecrc_pkg::ADDR_COUNT_LOW;
    assign wr_bh = bus_i.wr && !locked
        && bus_i.addr == tecrc_pkg::ADDR_PRELOAD_HIGH;
    assign wr_bl = bus_i.wr && !locked
        && bus_i.addr == tecrc_pkg::ADDR_PRELOAD_LOW;
    assign wr_ctl = bus_i.wr && bus_i.addr == tecrc_pkg::ADDR_COUNTER_CONTROL;
    assign wr_conv = bus_i.wr && bus_i.addr == tecrc_pkg::ADDR_CONV_CONTROL;
    assign rd_ah = bus_i.rd && !locked
        && bus_i.addr == tecrc_pkg::ADDR_COUNT_HIGH;
    assign rd_bh = bus_i.rd && !locked
        && bus_i.addr == tecrc_pkg::ADDR_PRELOAD_HIGH;

    ////////////////////////////////////////////////////////////////
    // Clock sources

    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            div_q <= '0;
        end else begin
            div_q <= div_q + 1'b1;
        end
    end
    assign instr_tick = (div_q == INSTR_DIV_W_L'(tecrc_pkg::INSTR_DIV - 1));

    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pin_q <= 1'b0;
        end else begin
            pin_q <= count_input_pin_i;
        end
    end
    assign pin_edge_rise = count_input_pin_i && !pin_q;
    assign pin_edge_fall = !count_input_pin_i && pin_q;

    // Timer B source per oscillator code
    always_comb begin
        b_src = 1'b0;
        unique case (osc_sel)
            4'h0: b_src = src_i.ext_clk[0];
            4'h1, 4'h2, 4'h3, 4'h4: b_src = src_i.rc_osc[osc_sel[2:0] - 3'h1];
            4'h5: b_src = src_i.rc_osc[3];
            4'h6: b_src = src_i.rc_osc[4];
            4'h7: b_src = src_i.ext_clk[1];
            default: b_src = 1'b0;
        endcase
    end

    // Mode code decode, timer A clock in converter mode
    always_comb begin
        a_src = 1'b0;
        unique case (mode)
            tecrc_pkg::TECRC_MODE_SYS: a_src = 1'b1;
            tecrc_pkg::TECRC_MODE_INSTR: a_src = instr_tick;
            tecrc_pkg::TECRC_MODE_RTC: a_src = src_i.rtc_tick;
            tecrc_pkg::TECRC_MODE_ADCLK: a_src = conv_mode ? 1'b0 : b_src;
            tecrc_pkg::TECRC_MODE_EVENT: begin
                a_src = conv_mode ? 1'b0
                    : (ctl_q[tecrc_pkg::CTL_EDGE_BIT] ? pin_edge_fall
                                                       : pin_edge_rise);
            end
            tecrc_pkg::TECRC_MODE_PWIDTH: begin
                a_src = conv_mode ? 1'b0 : (pw_active_q && instr_tick);
            end
            default: a_src = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////
    // Pulse width measurement

    // Start on chosen edge, stop on return
    assign pw_start = !pw_active_q && (ctl_q[tecrc_pkg::CTL_EDGE_BIT]
        ? pin_edge_rise : pin_edge_fall);
    assign pw_end = pw_active_q && (ctl_q[tecrc_pkg::CTL_EDGE_BIT]
        ? pin_edge_fall : pin_edge_rise);

    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pw_active_q <= 1'b0;
        end else if (!count_on || conv_mode
            || mode != tecrc_pkg::TECRC_MODE_PWIDTH) begin
            pw_active_q <= 1'b0;
        end else if (pw_start) begin
            pw_active_q <= 1'b1;
        end else if (pw_end) begin
            pw_active_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Counters

    // Reads are refused while counting, so the stall only
    // guards the cycle in which counting is switched on
    // Count high read stalls one cycle
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rd_stall_q <= 1'b0;
        end else begin
            rd_stall_q <= rd_ah;
        end
    end

    assign a_tick = count_on && a_src && !rd_ah && !rd_stall_q;
    // Timer B counts only in converter mode
    assign b_tick = count_on && conv_mode && b_src && !rd_bh;

    assign ld_a = wr_ah || (!conv_mode && wr_bh);
    assign ld_b = conv_mode && wr_bh;

    // High write merges buffered low byte
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            wr_buf_a_q <= 8'h00;
            wr_buf_b_q <= 8'h00;
            preload_q <= 16'h0000;
        end else begin
            if (wr_al) begin
                wr_buf_a_q <= bus_i.wdata;
            end
            if (wr_bl) begin
                wr_buf_b_q <= bus_i.wdata;
            end
            if (wr_bh) begin
                preload_q <= {bus_i.wdata, wr_buf_b_q};
            end
        end
    end

    // Overflow reloads from preload outside converter mode, also in pulse width
    tecrc_counter16 u_cnt_a (
        .sys_clk_i(sys_clk_i),
        .reset_n_i(reset_n_i),
        .tick_i(a_tick),
        .load_i(ld_a),
        .load_val_i(wr_ah ? {bus_i.wdata, wr_buf_a_q}
                          : {bus_i.wdata, wr_buf_b_q}),
        .reload_i(!conv_mode),
        .reload_val_i(preload_q),
        .capture_i(rd_ah),
        .count_o(cnt_a),
        .low_buf_o(lbuf_a),
        .ovf_o(ovf_a)
    );

    tecrc_counter16 u_cnt_b (
        .sys_clk_i(sys_clk_i),
        .reset_n_i(reset_n_i),
        .tick_i(b_tick),
        .load_i(ld_b),
        .load_val_i({bus_i.wdata, wr_buf_b_q}),
        .reload_i(1'b0),
        .reload_val_i(16'h0000),
        .capture_i(rd_bh),
        .count_o(cnt_b),
        .low_buf_o(lbuf_b),
        .ovf_o(ovf_b)
    );

    assign ovf_evt = conv_mode
        ? (conv_q[tecrc_pkg::CONV_OVSRC_BIT] ? ovf_b : ovf_a) : ovf_a;

    ////////////////////////////////////////////////////////////////
    // Control registers

    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ctl_q <= tecrc_pkg::CTL_RESET;
        end else begin
            if (wr_ctl) begin
                ctl_q <= bus_i.wdata & tecrc_pkg::CTL_RD_MASK;
            end
            if (conv_mode && ovf_evt) begin
                ctl_q[tecrc_pkg::CTL_ON_BIT] <= 1'b0;
            end else if (!conv_mode && pw_end
                && mode == tecrc_pkg::TECRC_MODE_PWIDTH && count_on) begin
                ctl_q[tecrc_pkg::CTL_ON_BIT] <= 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            conv_q <= tecrc_pkg::CONV_RESET;
        end else if (wr_conv) begin
            conv_q <= bus_i.wdata & tecrc_pkg::CONV_RD_MASK;
        end
    end

    // Sticky flag, set wins over clear
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            flag_q <= 1'b0;
        end else if (ovf_evt) begin
            flag_q <= 1'b1;
        end else if (flag_wr_i && !flag_wdata_i) begin
            flag_q <= 1'b0;
        end
    end
    assign overflow_flag_o = flag_q;
    assign int_req_o = flag_q && timer_int_enable_i;
    assign wakeup_o = flag_q;

    // Half the overflow rate keeps the pin a square wave
    // Divider toggles on each overflow
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pfd_q <= 1'b0;
        end else if (ovf_evt) begin
            pfd_q <= !pfd_q;
        end
    end
    // Port bit set forces pin low
    assign freq_divider_output_o = DIVIDER_OPTION && !divider_port_bit_i
        && pfd_q;

    ////////////////////////////////////////////////////////////////
    // Read mux; locked locations read zero

    always_comb begin
        rdata_o = 8'h00;
        if (bus_i.rd) begin
            unique case (bus_i.addr)
                tecrc_pkg::ADDR_COUNT_HIGH: rdata_o = locked ? 8'h00
                                                     : cnt_a[15:8];
                tecrc_pkg::ADDR_COUNT_LOW: rdata_o = locked ? 8'h00 : lbuf_a;
                tecrc_pkg::ADDR_PRELOAD_HIGH: begin
                    rdata_o = locked ? 8'h00
                        : (conv_mode ? cnt_b[15:8] : preload_q[15:8]);
                end
                tecrc_pkg::ADDR_PRELOAD_LOW: begin
                    rdata_o = locked ? 8'h00
                        : (conv_mode ? lbuf_b : preload_q[7:0]);
                end
                tecrc_pkg::ADDR_COUNTER_CONTROL: rdata_o = ctl_q;
                tecrc_pkg::ADDR_CONV_CONTROL: rdata_o = conv_q;
                default: rdata_o = 8'h00;
            endcase
        end
    end

endmodule

//--- rtl/tecrc_pkg.sv
package tecrc_pkg;

    // Register byte addresses in the data memory map
    localparam logic [7:0] ADDR_COUNT_HIGH = 8'h20;
    localparam logic [7:0] ADDR_COUNT_LOW = 8'h21;
    localparam logic [7:0] ADDR_COUNTER_CONTROL = 8'h22;
    localparam logic [7:0] ADDR_PRELOAD_HIGH = 8'h23;
    localparam logic [7:0] ADDR_PRELOAD_LOW = 8'h24;
    localparam logic [7:0] ADDR_CONV_CONTROL = 8'h25;

    // Field positions
    localparam int CTL_EDGE_BIT = 3;
    localparam int CTL_ON_BIT = 4;
    localparam int CTL_MODE_LSB = 5;
    localparam int CONV_OVSRC_BIT = 0;
    localparam int CONV_MODE_BIT = 1;
    localparam int CONV_OSC_LSB = 4;

    // Reset values and register masks
    localparam logic [7:0] CTL_RESET = 8'h08;
    localparam logic [7:0] CONV_RESET = 8'h80;
    localparam logic [7:0] CTL_RD_MASK = 8'hf8;
    localparam logic [7:0] CONV_RD_MASK = 8'hf3;

    // Instruction clock is the system clock divided by four
    localparam int INSTR_DIV = 4;
    localparam int INSTR_DIV_W = 2;

    typedef enum logic [2:0] {
        TECRC_MODE_SYS = 3'h0,
        TECRC_MODE_INSTR = 3'h1,
        TECRC_MODE_RTC = 3'h2,
        TECRC_MODE_ADCLK = 3'h3,
        TECRC_MODE_EVENT = 3'h4,
        TECRC_MODE_PWIDTH = 3'h5,
        TECRC_MODE_UNUSED6 = 3'h6,
        TECRC_MODE_UNUSED7 = 3'h7
    } tecrc_mode_t;

    // Processor register port
    typedef struct packed {
        logic rd;
        logic wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } tecrc_bus_req_t;

    // Clock sources offered to the block from the surroundings
    typedef struct packed {
        logic rtc_tick;
        logic [1:0] ext_clk;
        logic [4:0] rc_osc;
    } tecrc_src_t;

endpackage

//--- rtl/tecrc_counter16.sv
`timescale 1ns/1ps
// One 16-bit up-counter with reload and buffered byte access
module tecrc_counter16 (
    input wire logic sys_clk_i,
    input wire logic reset_n_i,
    input wire logic tick_i,
    input wire logic load_i,
    input wire logic [15:0] load_val_i,
    input wire logic reload_i,
    input wire logic [15:0] reload_val_i,
    input wire logic capture_i,
    output logic [15:0] count_o,
    output logic [7:0] low_buf_o,
    output logic ovf_o
);

    assign ovf_o = tick_i && (count_o == 16'hffff);

    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            count_o <= 16'h0000;
        end else if (load_i) begin
            count_o <= load_val_i;
        end else if (ovf_o && reload_i) begin
            count_o <= reload_val_i;
        end else if (tick_i) begin
            count_o <= count_o + 16'h0001;
        end
    end

    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            low_buf_o <= 8'h00;
        end else if (capture_i) begin
            low_buf_o <= count_o[7:0];
        end
    end

endmodule

//--- sim/tecrc_far_end.sv
`timescale 1ns/1ps
module tecrc_far_end (
    input wire logic sys_clk_i,
    input wire logic reset_n_i,
    input wire logic pin_toggle_i,
    input wire logic pin_level_i,
    output tecrc_pkg::tecrc_src_t src_o,
    output logic count_input_pin_o
);
    logic [1:0] phase_q;
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            phase_q <= 2'h0;
        end else begin
            phase_q <= phase_q + 2'h1;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // Oscillators run free
    // All sources pulse together, so select codes 0 to 7 see a clock
    assign src_o = tecrc_pkg::tecrc_src_t'((phase_q == 2'h3) ? 8'hff : 8'h00);
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            count_input_pin_o <= 1'b0;
        end else if (!pin_toggle_i) begin
            count_input_pin_o <= pin_level_i;
        end else if (phase_q == 2'h1) begin
            count_input_pin_o <= !count_input_pin_o;
        end
    end
endmodule

//--- sim/tecrc_timer_monitor.sv
`timescale 1ns/1ps
module tecrc_timer_monitor #(
    parameter bit DIVIDER_OPTION = 1'b1
) (
    input wire logic sys_clk_i,
    input wire logic reset_n_i,
    input wire tecrc_pkg::tecrc_bus_req_t bus_i,
    input wire logic [7:0] rdata_o,
    input wire logic timer_int_enable_i,
    input wire logic flag_wr_i,
    input wire logic flag_wdata_i,
    input wire logic divider_port_bit_i,
    input wire logic overflow_flag_o,
    input wire logic int_req_o,
    input wire logic wakeup_o,
    input wire logic freq_divider_output_o
);
    default clocking mon_cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!reset_n_i);
    logic ctl_rd;
    logic conv_q;
    assign ctl_rd = bus_i.rd && bus_i.addr == tecrc_pkg::ADDR_COUNTER_CONTROL;
    // Converter mode shadow; the control byte is never locked
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            conv_q <= 1'b0;
        end else if (bus_i.wr
            && bus_i.addr == tecrc_pkg::ADDR_CONV_CONTROL) begin
            conv_q <= bus_i.wdata[tecrc_pkg::CONV_MODE_BIT];
        end
    end
    ////////////////////////////////////////////////////////////////////////
    property p_int_gate;
        int_req_o == (overflow_flag_o && timer_int_enable_i);
    endproperty
    property p_wake;
        wakeup_o == overflow_flag_o;
    endproperty
    property p_div_low;
        divider_port_bit_i |-> !freq_divider_output_o;
    endproperty
    property p_div_toggle;
        $rose(overflow_flag_o) && DIVIDER_OPTION && !conv_q
            && !$past(flag_wr_i) && !divider_port_bit_i
            && !$past(divider_port_bit_i)
            |-> freq_divider_output_o != $past(freq_divider_output_o);
    endproperty
    property p_flag_sticky;
        overflow_flag_o && !(flag_wr_i && !flag_wdata_i) |=> overflow_flag_o;
    endproperty
    // Outside converter mode, timer modes below pulse width never drop count_on by themselves
    property p_locked_read;
        (ctl_rd && rdata_o[4] && rdata_o[7:5] < 3'h5 && !conv_q) ##1 !bus_i.wr
            ##1 (bus_i.rd && bus_i.addr == tecrc_pkg::ADDR_COUNT_HIGH)
            |-> rdata_o == 8'h00;
    endproperty
    property p_idle_read;
        !bus_i.rd |-> rdata_o == 8'h00;
    endproperty
    property p_ctl_bits;
        ctl_rd |-> rdata_o[2:0] == 3'h0;
    endproperty
    a_int_gate: assert property (p_int_gate)
        else $error("interrupt request not flag and enable");
    a_wake: assert property (p_wake)
        else $error("wakeup differs from overflow flag");
    a_div_low: assert property (p_div_low)
        else $error("divider pin not low while disabled");
    a_div_toggle: assert property (p_div_toggle)
        else $error("divider did not toggle on overflow");
    a_flag_sticky: assert property (p_flag_sticky)
        else $error("overflow flag dropped without a clear");
    a_locked_read: assert property (p_locked_read)
        else $error("count byte readable while counting");
    a_idle_read: assert property (p_idle_read)
        else $error("read data driven without a read");
    a_ctl_bits: assert property (p_ctl_bits)
        else $error("control unused bits not zero");
    c_flag: cover property ($rose(overflow_flag_o));
    c_int: cover property (int_req_o);
    c_div: cover property ($changed(freq_divider_output_o));
endmodule

bind tecrc_timer tecrc_timer_monitor #(.DIVIDER_OPTION(DIVIDER_OPTION)) u_mon (
    .sys_clk_i, .reset_n_i, .bus_i, .rdata_o, .timer_int_enable_i,
    .flag_wr_i, .flag_wdata_i, .divider_port_bit_i, .overflow_flag_o,
    .int_req_o, .wakeup_o, .freq_divider_output_o
);

//--- sim/tb_tecrc_timer.sv
`timescale 1ns/1ps
module tb_tecrc_timer;
    logic sys_clk_i, reset_n_i, count_input_pin_i, timer_int_enable_i;
    logic flag_wr_i, flag_wdata_i, divider_port_bit_i, pin_tog, pin_lvl;
    logic overflow_flag_o, int_req_o, wakeup_o, freq_divider_output_o;
    logic [7:0] rdata_o, rv, rv2;
    tecrc_pkg::tecrc_bus_req_t bus_i;
    tecrc_pkg::tecrc_src_t src_i;
    int error_cnt, tests_run;

    tecrc_timer DUT (.sys_clk_i, .reset_n_i, .bus_i, .rdata_o, .src_i,
        .count_input_pin_i, .timer_int_enable_i, .flag_wr_i, .flag_wdata_i,
        .divider_port_bit_i, .overflow_flag_o, .int_req_o, .wakeup_o,
        .freq_divider_output_o);
    tecrc_far_end u_far (.sys_clk_i, .reset_n_i, .pin_toggle_i(pin_tog),
        .pin_level_i(pin_lvl), .src_o(src_i),
        .count_input_pin_o(count_input_pin_i));

    initial begin
        sys_clk_i = 1'b0;
        forever #25 sys_clk_i = ~sys_clk_i;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic step();
        @(posedge sys_clk_i);
        #1;
    endtask
    task automatic cmp8(input string nm, input logic [7:0] e,
            input logic [7:0] g);
        tests_run++;
        if (g !== e) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Each access is one strobe cycle and one idle cycle
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bus_i.wr = 1'b1;
        bus_i.addr = a;
        bus_i.wdata = d;
        @(posedge sys_clk_i);
        #1 bus_i.wr = 1'b0;
        step();
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        bus_i.rd = 1'b1;
        bus_i.addr = a;
        @(posedge sys_clk_i);
        d = rdata_o;
        #1 bus_i.rd = 1'b0;
        step();
    endtask
    task automatic chk(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        rd(a, d);
        cmp8($sformatf("register %h", a), e, d);
    endtask
    task automatic clr_flag();
        flag_wr_i = 1'b1;
        @(posedge sys_clk_i);
        #1 flag_wr_i = 1'b0;
        step();
    endtask
    task automatic wait_flag(input int lim);
        int n;
        n = 0;
        while (overflow_flag_o !== 1'b1 && n < lim) begin
            step();
            n++;
        end
        cmp8("overflow flag", 8'h01, {7'h0, overflow_flag_o});
    endtask
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        error_cnt = 0;
        tests_run = 0;
        bus_i = '0;
        reset_n_i = 1'b0;
        {pin_tog, pin_lvl, flag_wr_i, flag_wdata_i, divider_port_bit_i} = '0;
        timer_int_enable_i = 1'b1;
        repeat (6) @(posedge sys_clk_i);
        #1 reset_n_i = 1'b1;
        chk(tecrc_pkg::ADDR_COUNTER_CONTROL, tecrc_pkg::CTL_RESET);
        chk(tecrc_pkg::ADDR_CONV_CONTROL, tecrc_pkg::CONV_RESET);
        $display("test reset_values done");
        wr(tecrc_pkg::ADDR_PRELOAD_LOW, 8'h34);
        chk(tecrc_pkg::ADDR_COUNT_HIGH, 8'h00);
        wr(tecrc_pkg::ADDR_PRELOAD_HIGH, 8'h12);
        chk(tecrc_pkg::ADDR_COUNT_HIGH, 8'h12);
        chk(tecrc_pkg::ADDR_COUNT_LOW, 8'h34);
        wr(tecrc_pkg::ADDR_COUNT_LOW, 8'h56);
        wr(tecrc_pkg::ADDR_COUNT_HIGH, 8'h78);
        chk(tecrc_pkg::ADDR_COUNT_HIGH, 8'h78);
        chk(tecrc_pkg::ADDR_COUNT_LOW, 8'h56);
        $display("test byte_buffering done");
        wr(tecrc_pkg::ADDR_CONV_CONTROL, 8'h10);
        for (int m = 0; m < 5; m++) begin
            wr(tecrc_pkg::ADDR_PRELOAD_LOW, 8'hf8);
            wr(tecrc_pkg::ADDR_PRELOAD_HIGH, 8'hff);
            clr_flag();
            pin_tog = (m == 4);
            wr(tecrc_pkg::ADDR_COUNTER_CONTROL, {m[2:0], 5'h10});
            wait_flag(300);
            chk(tecrc_pkg::ADDR_COUNTER_CONTROL, {m[2:0], 5'h10});
            chk(tecrc_pkg::ADDR_COUNT_HIGH, 8'h00);
            wr(tecrc_pkg::ADDR_COUNTER_CONTROL, {m[2:0], 5'h00});
            chk(tecrc_pkg::ADDR_COUNT_HIGH, 8'hff);
            rd(tecrc_pkg::ADDR_COUNT_LOW, rv);
            cmp8("reload low", 8'h01, {7'h0, rv >= 8'hf8});
            cmp8("int request", 8'h01, {7'h0, int_req_o});
            cmp8("wakeup", 8'h01, {7'h0, wakeup_o});
        end
        pin_tog = 1'b0;
        timer_int_enable_i = 1'b0;
        divider_port_bit_i = 1'b1;
        step();
        cmp8("int masked", 8'h00, {7'h0, int_req_o});
        cmp8("divider pin", 8'h00, {7'h0, freq_divider_output_o});
        clr_flag();
        cmp8("flag cleared", 8'h00, {7'h0, overflow_flag_o});
        {timer_int_enable_i, divider_port_bit_i} = 2'b10;
        $display("test timer_modes done");
        wr(tecrc_pkg::ADDR_PRELOAD_LOW, 8'h00);
        wr(tecrc_pkg::ADDR_PRELOAD_HIGH, 8'h00);
        // Unused mode code must not count
        wr(tecrc_pkg::ADDR_COUNTER_CONTROL, 8'hd0);
        repeat (20) step();
        wr(tecrc_pkg::ADDR_COUNTER_CONTROL, 8'h00);
        chk(tecrc_pkg::ADDR_COUNT_HIGH, 8'h00);
        chk(tecrc_pkg::ADDR_COUNT_LOW, 8'h00);
        wr(tecrc_pkg::ADDR_COUNTER_CONTROL, 8'hb8);
        for (int p = 0; p < 2; p++) begin
            pin_lvl = 1'b1;
            repeat (40) @(posedge sys_clk_i);
            #1 pin_lvl = 1'b0;
            repeat (8) step();
            chk(tecrc_pkg::ADDR_COUNTER_CONTROL, 8'ha8);
            chk(tecrc_pkg::ADDR_COUNT_HIGH, 8'h00);
            rd(tecrc_pkg::ADDR_COUNT_LOW, rv2);
            if (p == 0) begin
                rv = rv2;
            end
            cmp8("pulse len", 8'h01, {7'h0, rv2 inside {[8'h09:8'h0b]}});
            cmp8("pulse held", rv, rv2);
        end
        $display("test pulse_width done");
        wr(tecrc_pkg::ADDR_CONV_CONTROL, 8'h12);
        wr(tecrc_pkg::ADDR_COUNT_LOW, 8'hf0);
        wr(tecrc_pkg::ADDR_COUNT_HIGH, 8'hff);
        wr(tecrc_pkg::ADDR_PRELOAD_LOW, 8'h00);
        wr(tecrc_pkg::ADDR_PRELOAD_HIGH, 8'h00);
        clr_flag();
        wr(tecrc_pkg::ADDR_COUNTER_CONTROL, 8'h10);
        wait_flag(60);
        chk(tecrc_pkg::ADDR_COUNTER_CONTROL, 8'h00);
        chk(tecrc_pkg::ADDR_PRELOAD_HIGH, 8'h00);
        rd(tecrc_pkg::ADDR_PRELOAD_LOW, rv);
        cmp8("timer b count", 8'h01, {7'h0, rv inside {[8'h02:8'h06]}});
        for (int c = 0; c < 8; c++) begin
            wr(tecrc_pkg::ADDR_CONV_CONTROL, {c[3:0], 4'h3});
            wr(tecrc_pkg::ADDR_PRELOAD_LOW, 8'hfc);
            wr(tecrc_pkg::ADDR_PRELOAD_HIGH, 8'hff);
            clr_flag();
            wr(tecrc_pkg::ADDR_COUNTER_CONTROL, 8'h10);
            wait_flag(60);
            chk(tecrc_pkg::ADDR_COUNTER_CONTROL, 8'h00);
        end
        $display("test converter done");
        complete_run();
    end
    // Whole run needs under a thousand cycles
    initial begin
        repeat (20000) @(posedge sys_clk_i);
        error_cnt++;
        $display("watchdog expired");
        complete_run();
    end
endmodule
